// ### rtl/rte_pkg.sv
// package for the tamper edge detection block
package rte_pkg;
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_MASK     = 12'h008;
   localparam logic [11:0] ADDR_PIN      = 12'h00C;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_POL_BIT  = 1;
   localparam int          CTRL_FLT_LSB  = 2;
   localparam int          ST_EVT_BIT    = 0;
   localparam int          ST_SPUR_BIT   = 1;
   localparam logic [1:0]  FLT_EDGE      = 2'h0;
   localparam logic [3:0]  CTRL_RESET    = 4'h0;
   localparam logic [1:0]  STATUS_RESET  = 2'h0;
   localparam logic [1:0]  MASK_RESET    = 2'h0;
   localparam logic        POL_RISING    = 1'h0;
   localparam logic        POL_FALLING   = 1'h1;
endpackage : rte_pkg

// ### rtl/rte_tamper_edge.sv
// tamper pin edge detection with apb registers and interrupt
//
// Operation
// - filter select of zero puts the tamper input in edge detection mode
// - polarity zero detects rising edges, polarity one detects falling edges
// - falling edge mode: disabling with pin high raises a false event
// - falling edge mode: pin already low at enable gives no event
// - rising edge mode: pin already high at enable gives no event
`timescale 1ns/10ps
`default_nettype none
module rte_tamper_edge
   import rte_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        TAMPER_PIN,
   output logic             TAMPER_EVENT,
   output logic             IRQ
);
   logic        pin_s1_r;
   logic        pin_s2_r;
   logic        pin_d_r;
   logic        en_d_r;
   logic [3:0]  ctrl_r;
   logic [3:0]  ctrl_nxt;
   logic [1:0]  status_r;
   logic [1:0]  status_nxt;
   logic [1:0]  mask_r;
   logic [1:0]  mask_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pready_r;
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic        evt_r;
   logic        evt_nxt;
   logic        en;
   logic        pol;
   logic        edge_mode;
   logic        rise;
   logic        fall;
   logic        hit;
   logic        spur;
   logic        wr;
   logic        rd;
   logic        acc;
   logic        mapped;
   logic        pin_d_nxt;
   logic        en_d_nxt;

   // pin synchroniser
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_r <= 1'h0;
         pin_s2_r <= 1'h0;
      end else begin
         pin_s1_r <= TAMPER_PIN;
         pin_s2_r <= pin_s1_r;
      end
   end

   assign en        = ctrl_r[CTRL_EN_BIT];
   assign pol       = ctrl_r[CTRL_POL_BIT];
   assign edge_mode = (ctrl_r[CTRL_FLT_LSB+1:CTRL_FLT_LSB] == FLT_EDGE);
   // previous level is taken even while disabled, so a level present
   // at enable is no edge; rising side likewise gives no event for a high pin
   assign rise = pin_s2_r && !pin_d_r;
   assign fall = !pin_s2_r && pin_d_r;
   assign hit  = en && en_d_r && edge_mode &&
                 ((pol == POL_RISING) ? rise : fall);
   // disabling in falling mode with pin high flags a false event
   assign spur = en_d_r && !en && edge_mode && (pol == POL_FALLING) &&
                 pin_s2_r;

   // first access cycle; the answer follows one edge later
   assign acc    = PSEL && PENABLE && !pready_r;
   assign mapped = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) ||
                   (PADDR == ADDR_MASK) || (PADDR == ADDR_PIN);
   // writes land on the edge that samples pready high
   assign wr = PSEL && PENABLE && PWRITE && pready_r;
   // read data registered so that it stands while pready is high
   assign rd = acc && !PWRITE;

   // bus side registers
   always_comb begin
      ctrl_nxt    = ctrl_r;
      mask_nxt    = mask_r;
      prdata_nxt  = prdata_r;
      pready_nxt  = acc;
      pslverr_nxt = acc && !mapped;
      if (wr) begin
         if (PADDR == ADDR_CTRL) begin
            ctrl_nxt = PWDATA[3:0];
         end else if (PADDR == ADDR_MASK) begin
            mask_nxt = PWDATA[1:0];
         end
      end
      if (rd) begin
         prdata_nxt = 32'h0000_0000;
         if (PADDR == ADDR_CTRL) begin
            prdata_nxt[3:0] = ctrl_r;
         end else if (PADDR == ADDR_STATUS) begin
            prdata_nxt[1:0] = status_r;
         end else if (PADDR == ADDR_MASK) begin
            prdata_nxt[1:0] = mask_r;
         end else if (PADDR == ADDR_PIN) begin
            prdata_nxt[0] = pin_s2_r;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_r    <= CTRL_RESET;
         mask_r    <= MASK_RESET;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'h0;
         pslverr_r <= 1'h0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         mask_r    <= mask_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // event side state
   always_comb begin
      status_nxt = status_r;
      if (wr && (PADDR == ADDR_STATUS)) begin
         status_nxt = status_r & ~PWDATA[1:0];
      end
      // set wins over clear
      if (hit) begin
         status_nxt[ST_EVT_BIT] = 1'h1;
      end
      if (spur) begin
         status_nxt[ST_SPUR_BIT] = 1'h1;
      end
      evt_nxt   = status_nxt[ST_EVT_BIT] | status_nxt[ST_SPUR_BIT];
      irq_nxt   = |(status_nxt & mask_nxt);
      pin_d_nxt = pin_s2_r;
      en_d_nxt  = en;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         status_r <= STATUS_RESET;
         irq_r    <= 1'h0;
         evt_r    <= 1'h0;
         pin_d_r  <= 1'h0;
         en_d_r   <= 1'h0;
      end else begin
         status_r <= status_nxt;
         irq_r    <= irq_nxt;
         evt_r    <= evt_nxt;
         pin_d_r  <= pin_d_nxt;
         en_d_r   <= en_d_nxt;
      end
   end

   assign PRDATA       = prdata_r;
   assign PREADY       = pready_r;
   assign PSLVERR      = pslverr_r;
   assign TAMPER_EVENT = evt_r;
   assign IRQ          = irq_r;

   a_edge_mode_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !edge_mode |-> !hit) else $error("edge hit outside edge mode");
   a_rise_sets: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (en && en_d_r && edge_mode && !pol && rise) |=> status_r[ST_EVT_BIT])
      else $error("rising edge not flagged");
   a_fall_sets: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (en && en_d_r && edge_mode && pol && fall) |=> status_r[ST_EVT_BIT])
      else $error("falling edge not flagged");
   a_disable_spur: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($fell(en) && edge_mode && pol && pin_s2_r) |=> status_r[ST_SPUR_BIT])
      else $error("false event on disable missing");
   a_low_no_evt: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(en) && edge_mode && pol && !pin_s2_r && !pin_d_r)
      |=> !$rose(status_r[ST_EVT_BIT]))
      else $error("event for level low at enable");
   a_high_no_evt: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(en) && edge_mode && !pol && pin_s2_r && pin_d_r)
      |=> !$rose(status_r[ST_EVT_BIT]))
      else $error("event for level high at enable");
   a_wrong_pol: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (en && en_d_r && edge_mode && !pol && fall)
      |=> !$rose(status_r[ST_EVT_BIT]))
      else $error("falling edge flagged in rising mode");
   a_spur_rising: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($fell(en) && !pol)
      |=> !$rose(status_r[ST_SPUR_BIT]))
      else $error("false event in rising mode");
   a_idle_no_evt: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !en_d_r
      |=> !$rose(status_r[ST_EVT_BIT]))
      else $error("event while disabled");
   a_evt_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ##1 (TAMPER_EVENT == |status_r))
      else $error("event output mismatch");
   a_ctrl_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (wr && PADDR == ADDR_CTRL)
      |=> (ctrl_r == $past(PWDATA[3:0])))
      else $error("control write lost");
   a_ctrl_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !(wr && PADDR == ADDR_CTRL)
      |=> $stable(ctrl_r))
      else $error("control changed without write");
   a_ready_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PREADY
      |=> !PREADY)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (PSEL && PENABLE && !PREADY && !mapped)
      |=> PSLVERR)
      else $error("no error on unmapped address");
   a_err_with_ready: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PSLVERR
      |-> PREADY)
      else $error("error without pready");
   a_sticky_evt: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (status_r[ST_EVT_BIT] && !(wr && PADDR == ADDR_STATUS && PWDATA[0]))
      |=> status_r[ST_EVT_BIT]) else $error("event flag lost");
   a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ##1 (IRQ == |(status_r & mask_r))) else $error("irq mismatch");
   a_apb_ready: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (PSEL && PENABLE && !pready_r) |=> PREADY) else $error("no pready");
endmodule : rte_tamper_edge
`default_nettype wire

// ### test/rte_pin_model.sv
// pin model driving the tamper input
`timescale 1ns/10ps
`default_nettype none
module rte_pin_model (
   input  wire logic clk,
   input  wire logic lvl,
   output logic      pin
);
   initial pin = 1'b0;
   // pin moves just after a clock edge
   always @(posedge clk) begin
      pin <= lvl;
   end
endmodule : rte_pin_model
`default_nettype wire

// ### test/test_rtc_tamper_edge_detect.sv
// self-checking bench for the tamper edge block
`timescale 1ns/10ps
`default_nettype none
module test_rtc_tamper_edge_detect
   import rte_pkg::*;
;
   typedef struct {logic [1:0] flt; logic pol, l0, l1; logic [1:0] st;} rte_row_t;
   logic        CORE_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
   logic        PWRITE = 1'b0, lvl = 1'b0, e;
   logic        PREADY, PSLVERR, TAMPER_PIN, TAMPER_EVENT, IRQ;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, q;
   int          n_fail = 0, cmp_count = 0;
   rte_row_t    rows [7] = '{'{2'h0, 1'b0, 1'b0, 1'b1, 2'h1},
      '{2'h0, 1'b0, 1'b1, 1'b0, 2'h0}, '{2'h0, 1'b1, 1'b1, 1'b0, 2'h1},
      '{2'h0, 1'b1, 1'b0, 1'b1, 2'h0}, '{2'h0, 1'b1, 1'b0, 1'b0, 2'h0},
      '{2'h0, 1'b0, 1'b1, 1'b1, 2'h0}, '{2'h1, 1'b0, 1'b0, 1'b1, 2'h0}};
   always #4 CORE_CLK = ~CORE_CLK;
   rte_pin_model i_pin (.clk(CORE_CLK), .lvl(lvl), .pin(TAMPER_PIN));
   rte_tamper_edge i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .TAMPER_PIN(TAMPER_PIN), .TAMPER_EVENT(TAMPER_EVENT), .IRQ(IRQ));
   task automatic wrap_up;
      $display("checks %0d fails %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge CORE_CLK);
      PSEL    <= 1'b1;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   initial begin
      #100000;
      n_fail++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      rd(ADDR_MASK, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, ADDR_CTRL, 32'h0);
         lvl <= rows[i].l0;
         repeat (6) @(posedge CORE_CLK);
         apb(1'b1, ADDR_STATUS, 32'h3);
         apb(1'b1, ADDR_CTRL, {28'h0, rows[i].flt, rows[i].pol, 1'b1});
         lvl <= rows[i].l1;
         repeat (6) @(posedge CORE_CLK);
         rd(ADDR_PIN, {31'h0, rows[i].l1});
         rd(ADDR_STATUS, {30'h0, rows[i].st});
         chk({31'h0, TAMPER_EVENT}, {31'h0, |rows[i].st});
         $display("test row %0d done", i);
      end
      apb(1'b1, ADDR_CTRL, 32'h3);
      repeat (2) @(posedge CORE_CLK);
      apb(1'b1, ADDR_CTRL, 32'h2);
      repeat (4) @(posedge CORE_CLK);
      rd(ADDR_STATUS, 32'h2);
      chk({31'h0, IRQ}, 32'h0);
      apb(1'b1, ADDR_MASK, 32'h2);
      repeat (2) @(posedge CORE_CLK);
      chk({31'h0, IRQ}, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h2);
      repeat (2) @(posedge CORE_CLK);
      chk({31'h0, IRQ}, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      apb(1'b1, ADDR_PIN, 32'h0);
      rd(ADDR_PIN, 32'h1);
      rd(12'h010, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test awkward done");
      apb(1'b1, ADDR_MASK, 32'h3);
      apb(1'b1, ADDR_CTRL, 32'h3);
      lvl <= 1'b0;
      repeat (8) @(posedge CORE_CLK);
      chk({31'h0, IRQ}, 32'h1);
      RST_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      chk({30'h0, IRQ, TAMPER_EVENT}, 32'h0);
      RST_N <= 1'b1;
      rd(ADDR_STATUS, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_MASK, 32'h0);
      $display("test reset mid-run done");
      wrap_up;
   end
endmodule : test_rtc_tamper_edge_detect
`default_nettype wire
